//--- core/aspb_pkg.sv
// Purpose: Shared types and constants for the acquisition ping-pong buffer.
// Assumes: Eight converter channels of 16 bits, one core clock of 100 MHz.
// Notes:   Memory depth is a fixed localparam; each hardware buffer is half of it.
package aspb_pkg;
	localparam int          NUM_CH         = 8;
	localparam int          CH_IDX_W       = 3;
	localparam int          SAMPLE_W       = 16;
	localparam int          MEM_ADDR_W     = 12;
	localparam int          MEM_DEPTH      = 4096;
	localparam int          HALF_DEPTH     = 2048;
	localparam int          LEN_W          = 12;
	localparam int          FIFO_DEPTH     = 4;
	localparam int          FIFO_PTR_W     = 2;
	localparam int          CLK_MHZ        = 100;
	localparam int          SRC_RATE_KSPS  = 125000;
	localparam logic [15:0] POS_FULL_SCALE = 16'h7d00;
	localparam logic [15:0] NEG_FULL_SCALE = 16'h8300;
	localparam logic [15:0] OFFSET_RESET   = 16'h0000;
	localparam logic [LEN_W-1:0] BUF_LEN_RESET = 12'h400;
	localparam logic [7:0]  CH_MASK_RESET  = 8'h01;

	typedef struct packed {
		logic [CH_IDX_W-1:0] channel;
		logic [SAMPLE_W-1:0] data;
	} aspb_sample_type;

	typedef struct packed {
		logic [MEM_ADDR_W-1:0] addr;
		logic [SAMPLE_W-1:0]   data;
	} aspb_mem_word_type;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_ARMED   = 2'b01,
		ST_RUN     = 2'b10,
		ST_OVERRUN = 2'b11
	} aspb_state_type;
endpackage : aspb_pkg

//--- core/aspb_fifo.sv
// Purpose: Small valid/ready FIFO in the sample path.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Depth must be a power of two matching the pointer width.
`timescale 1ns/10ps
module aspb_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 4,
	parameter int PTR_W = 2
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] wr_ptr_next;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_next;
	logic [PTR_W:0]   count_reg;
	logic [PTR_W:0]   count_next;
	logic             push;
	logic             pop;

	assign in_ready  = (count_reg != DEPTH[PTR_W:0]);
	assign out_valid = (count_reg != '0);
	assign out_data  = mem_reg[rd_ptr_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		count_next  = count_reg;
		if (push) begin
			wr_ptr_next = wr_ptr_reg + 1'b1;
		end
		if (pop) begin
			rd_ptr_next = rd_ptr_reg + 1'b1;
		end
		if (push && !pop) begin
			count_next = count_reg + 1'b1;
		end else if (pop && !push) begin
			count_next = count_reg - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg  <= count_next;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end
endmodule : aspb_fifo

//--- core/aspb_top.sv
// Purpose: Acquisition sample path: offset correction, channel interleave and
//          a two-buffer continuous store into on-board sample memory.
// Assumes: Converter words arrive on pins and are synchronised here; the host
//          side reads memory through a read port and acknowledges each buffer.
// Notes:   Each hardware buffer fill raises a one-cycle event and sets FULL_BUFFER_INDEX to that buffer.
//          The host must release a filled buffer with BUFFER_DONE before the other
//          buffer fills, or the run stops with OVERRUN set.
`timescale 1ns/10ps

module aspb_top
	import aspb_pkg::*;
(
	input  wire logic                  CORE_CLK,
	input  wire logic                  RST,
	input  wire logic [SAMPLE_W*NUM_CH-1:0] CONVERTER_SAMPLE_BITS,
	input  wire logic                  SAMPLE_STROBE,
	input  wire logic [7:0]            CHANNEL_ENABLE,
	input  wire logic [SAMPLE_W-1:0]   OFFSET_CONST,
	input  wire logic [LEN_W-1:0]      BUFFER_LEN,
	input  wire logic                  START,
	input  wire logic                  STOP,
	input  wire logic                  SOFT_TRIGGER,
	input  wire logic                  EXT_TRIGGER,
	input  wire logic                  BUFFER_DONE,
	input  wire logic [MEM_ADDR_W-1:0] READ_ADDR,
	output logic [SAMPLE_W-1:0]        READ_DATA,
	output logic                       BUFFER_FULL_EVENT,
	output logic                       FULL_BUFFER_INDEX,
	output logic                       RUNNING,
	output logic                       ARMED,
	output logic                       OVERRUN
);
	logic [SAMPLE_W*NUM_CH-1:0] samp_meta_reg;
	logic [SAMPLE_W*NUM_CH-1:0] samp_meta_next;
	logic [SAMPLE_W*NUM_CH-1:0] samp_sync_reg;
	logic [SAMPLE_W*NUM_CH-1:0] samp_sync_next;
	logic [2:0]                 strobe_sync_reg;
	logic [2:0]                 strobe_sync_next;
	logic [1:0]                 trig_sync_reg;
	logic [1:0]                 trig_sync_next;
	logic                       trig_prev_reg;
	logic                       trig_prev_next;
	logic                       strobe_rise;
	logic                       trig_rise;

	// Converter words, strobe and pin trigger pass two flip-flops before any logic reads them; the edge detectors
	// compare the second stage with a third, and the second stage feeds the offset adders.
	always_comb begin
		samp_meta_next   = CONVERTER_SAMPLE_BITS;
		samp_sync_next   = samp_meta_reg;
		strobe_sync_next = {strobe_sync_reg[1:0], SAMPLE_STROBE};
		trig_sync_next   = {trig_sync_reg[0], EXT_TRIGGER};
		trig_prev_next   = trig_sync_reg[1];
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			samp_meta_reg   <= '0;
			samp_sync_reg   <= '0;
			strobe_sync_reg <= '0;
			trig_sync_reg   <= '0;
			trig_prev_reg   <= 1'b0;
		end else begin
			samp_meta_reg   <= samp_meta_next;
			samp_sync_reg   <= samp_sync_next;
			strobe_sync_reg <= strobe_sync_next;
			trig_sync_reg   <= trig_sync_next;
			trig_prev_reg   <= trig_prev_next;
		end
	end

	assign strobe_rise = strobe_sync_reg[1] && !strobe_sync_reg[2];
	assign trig_rise   = trig_sync_reg[1] && !trig_prev_reg;

	// Offset correction per channel, wrapping in 16 bits without clipping, so codes
	// beyond full scale reach memory untouched.
	logic [SAMPLE_W-1:0] corrected [NUM_CH];
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_corr
			assign corrected[gi] = samp_sync_reg[gi*SAMPLE_W +: SAMPLE_W]
				+ OFFSET_CONST;
		end
	endgenerate

	// Control state machine. A release that lands in the same cycle as the fill of
	// the other buffer counts as in time, so the host gets every cycle it can.
	// An overrun still marks the last buffer full, so the host can read it.
	aspb_state_type state_reg;
	aspb_state_type state_next;
	logic           wr_buf_reg;
	logic           wr_buf_next;
	logic [1:0]     pending_reg;
	logic [1:0]     pending_next;
	logic [LEN_W-1:0] fill_cnt_reg;
	logic [LEN_W-1:0] fill_cnt_next;
	logic [LEN_W-1:0] buf_len_reg;
	logic [LEN_W-1:0] buf_len_next;
	logic [7:0]     ch_mask_reg;
	logic [7:0]     ch_mask_next;
	logic           overrun_reg;
	logic           overrun_next;
	logic           event_reg;
	logic           event_next;
	logic           full_idx_reg;
	logic           full_idx_next;
	logic           capture;
	logic           mem_we;
	logic [MEM_ADDR_W-1:0] mem_waddr;

	// Sequencer state for round-robin interleave.
	logic [7:0]     scan_mask_reg;
	logic [7:0]     scan_mask_next;
	logic [SAMPLE_W*NUM_CH-1:0] hold_reg;
	logic [SAMPLE_W*NUM_CH-1:0] hold_next;
	logic           fifo_in_valid;
	logic           fifo_in_ready;
	aspb_sample_type fifo_in;
	aspb_sample_type fifo_out;
	logic           fifo_out_valid;
	logic           fifo_out_ready;
	logic [CH_IDX_W-1:0] pick_idx;
	logic           pick_any;

	// Words move toward memory only while a run is in progress.
	assign capture = (state_reg == ST_RUN);

	// Lowest pending channel of the current sample step.
	always_comb begin
		pick_idx = '0;
		pick_any = 1'b0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (scan_mask_reg[i]) begin
				pick_idx = i[CH_IDX_W-1:0];
				pick_any = 1'b1;
			end
		end
	end

	// A strobe that arrives before the previous step has drained is dropped.
	always_comb begin
		scan_mask_next = scan_mask_reg;
		hold_next      = hold_reg;
		fifo_in_valid  = 1'b0;
		fifo_in.channel = pick_idx;
		fifo_in.data    = hold_reg[pick_idx*SAMPLE_W +: SAMPLE_W];
		if (!capture) begin
			scan_mask_next = '0;
		end else if (pick_any) begin
			fifo_in_valid = 1'b1;
			if (fifo_in_ready) begin
				scan_mask_next[pick_idx] = 1'b0;
			end
		end else if (strobe_rise) begin
			// A step takes a load cycle, then one word a cycle, so eight channels at 100 MHz
			// need nine cycles per strobe, above a 12.5 MS/s strobe; lower counts go faster.
			scan_mask_next = ch_mask_reg;
			for (int i = 0; i < NUM_CH; i++) begin
				hold_next[i*SAMPLE_W +: SAMPLE_W] = corrected[i];
			end
		end
	end

	// Words of a step cut short by a stop or an overrun are dropped here, so that a
	// later run never writes them into its first buffer.
	logic fifo_rst;
	assign fifo_rst = RST || !capture;

	aspb_fifo #(
		.WIDTH ($bits(aspb_sample_type)),
		.DEPTH (FIFO_DEPTH),
		.PTR_W (FIFO_PTR_W)
	) u_fifo (
		.clk       (CORE_CLK),
		.rst       (fifo_rst),
		.in_data   (fifo_in),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready)
	);

	// Memory writes happen only during a run; while stopped the queue is flushed, not held.
	assign fifo_out_ready = capture;
	assign mem_we         = fifo_out_valid && capture;
	// The top address bit selects the hardware buffer being written.
	assign mem_waddr      = {wr_buf_reg, fill_cnt_reg[MEM_ADDR_W-2:0]};

	always_comb begin
		state_next    = state_reg;
		wr_buf_next   = wr_buf_reg;
		pending_next  = pending_reg;
		fill_cnt_next = fill_cnt_reg;
		buf_len_next  = buf_len_reg;
		ch_mask_next  = ch_mask_reg;
		overrun_next  = overrun_reg;
		event_next    = 1'b0;
		full_idx_next = full_idx_reg;
		// The host always releases the buffer that is not being written.
		if (BUFFER_DONE) begin
			pending_next[~wr_buf_reg] = 1'b0;
		end
		case (state_reg)
			ST_IDLE, ST_OVERRUN: begin
				// A new start clears the overrun flag and forgets any pending buffer.
				if (START) begin
					state_next    = ST_ARMED;
					overrun_next  = 1'b0;
					pending_next  = '0;
					wr_buf_next   = 1'b0;
					fill_cnt_next = '0;
					// A zero or oversized length falls back to half memory.
					if (BUFFER_LEN == '0 || BUFFER_LEN > HALF_DEPTH[LEN_W-1:0]) begin
						buf_len_next = HALF_DEPTH[LEN_W-1:0];
					end else begin
						buf_len_next = BUFFER_LEN;
					end
					// An empty channel mask falls back to channel 0 alone.
					ch_mask_next = (CHANNEL_ENABLE == '0) ? CH_MASK_RESET : CHANNEL_ENABLE;
				end
			end
			ST_ARMED: begin
				// The pin trigger counts only as a synchronised rising edge.
				if (STOP) begin
					state_next = ST_IDLE;
				end else if (SOFT_TRIGGER || trig_rise) begin
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (STOP) begin
					state_next = ST_IDLE;
				end else if (mem_we) begin
					// The last word of a buffer marks it pending; the write side flips to
					// the other buffer only when that one has been released.
					if (fill_cnt_reg == buf_len_reg - 1'b1) begin
						event_next    = 1'b1;
						full_idx_next = wr_buf_reg;
						fill_cnt_next = '0;
						pending_next[wr_buf_reg] = 1'b1;
						if (pending_reg[~wr_buf_reg] && !BUFFER_DONE) begin
							state_next   = ST_OVERRUN;
							overrun_next = 1'b1;
						end else begin
							wr_buf_next = ~wr_buf_reg;
						end
					end else begin
						fill_cnt_next = fill_cnt_reg + 1'b1;
					end
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state_reg    <= ST_IDLE;
			wr_buf_reg   <= 1'b0;
			pending_reg  <= '0;
			fill_cnt_reg <= '0;
			buf_len_reg  <= BUF_LEN_RESET;
			ch_mask_reg  <= CH_MASK_RESET;
			overrun_reg  <= 1'b0;
			event_reg    <= 1'b0;
			full_idx_reg <= 1'b0;
			scan_mask_reg <= '0;
			hold_reg     <= '0;
		end else begin
			state_reg    <= state_next;
			wr_buf_reg   <= wr_buf_next;
			pending_reg  <= pending_next;
			fill_cnt_reg <= fill_cnt_next;
			buf_len_reg  <= buf_len_next;
			ch_mask_reg  <= ch_mask_next;
			overrun_reg  <= overrun_next;
			event_reg    <= event_next;
			full_idx_reg <= full_idx_next;
			scan_mask_reg <= scan_mask_next;
			hold_reg     <= hold_next;
		end
	end

	// On-board sample memory with a registered read port.
	logic [SAMPLE_W-1:0] mem [MEM_DEPTH];
	logic [SAMPLE_W-1:0] rd_data_reg;
	logic [SAMPLE_W-1:0] rd_data_next;
	logic                running_reg;
	logic                running_next;
	logic                armed_reg;
	logic                armed_next;
	always_ff @(posedge CORE_CLK) begin
		if (mem_we) begin
			mem[mem_waddr] <= fifo_out.data;
		end
	end

	// Status levels follow the next state, so they change on the same edge as it;
	// the read port answers one cycle after the address.
	always_comb begin
		rd_data_next = mem[READ_ADDR];
		running_next = (state_next == ST_RUN);
		armed_next   = (state_next == ST_ARMED);
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			rd_data_reg <= '0;
			running_reg <= 1'b0;
			armed_reg   <= 1'b0;
		end else begin
			rd_data_reg <= rd_data_next;
			running_reg <= running_next;
			armed_reg   <= armed_next;
		end
	end

	assign READ_DATA         = rd_data_reg;
	assign BUFFER_FULL_EVENT = event_reg;
	assign FULL_BUFFER_INDEX = full_idx_reg;
	assign RUNNING           = running_reg;
	assign ARMED             = armed_reg;
	assign OVERRUN           = overrun_reg;
endmodule : aspb_top

//--- testbench/aspb_top_sva.sv
// Purpose: Control-output assertions for the ping-pong buffer.
// Assumes: Single clock, synchronous active-high reset.
// Notes:   Bound to the top module.
`timescale 1ns/10ps
module aspb_top_sva (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic START,
	input wire logic STOP,
	input wire logic SOFT_TRIGGER,
	input wire logic BUFFER_FULL_EVENT,
	input wire logic RUNNING,
	input wire logic ARMED,
	input wire logic OVERRUN
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);

	a_event_pulse: assert property (BUFFER_FULL_EVENT |=> !BUFFER_FULL_EVENT)
		else $error("full event held too long");
	a_event_running: assert property ($rose(BUFFER_FULL_EVENT) |-> $past(RUNNING))
		else $error("full event outside a run");
	a_start_arms: assert property (START && !STOP && !ARMED && !RUNNING |=> ARMED && !OVERRUN)
		else $error("start did not arm");
	a_soft_runs: assert property (ARMED && SOFT_TRIGGER && !STOP |=> RUNNING && !ARMED)
		else $error("soft trigger did not start");
	a_run_from_arm: assert property ($rose(RUNNING) |-> $past(ARMED))
		else $error("run without arming");
	a_state_excl: assert property (!(ARMED && RUNNING))
		else $error("armed and running together");
	a_overrun_stop: assert property ($rose(OVERRUN) |-> !RUNNING && !ARMED)
		else $error("overrun without stop");
	a_overrun_hold: assert property (OVERRUN && !START |=> OVERRUN)
		else $error("overrun flag dropped");
endmodule : aspb_top_sva

bind aspb_top aspb_top_sva u_sva (
	.CORE_CLK(CORE_CLK),
	.RST(RST),
	.START(START),
	.STOP(STOP),
	.SOFT_TRIGGER(SOFT_TRIGGER),
	.BUFFER_FULL_EVENT(BUFFER_FULL_EVENT),
	.RUNNING(RUNNING),
	.ARMED(ARMED),
	.OVERRUN(OVERRUN)
);

//--- testbench/aspb_host_model.sv
// Purpose: Host that drains each full buffer and releases it.
// Assumes: Read data arrives one cycle after the address.
// Notes:   The lag input makes it prompt or slow.
`timescale 1ns/10ps
module aspb_host_model
	import aspb_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  full_event,
	input  wire logic                  full_index,
	input  wire logic [SAMPLE_W-1:0]   read_data,
	input  wire logic [LEN_W-1:0]      buf_len,
	input  wire logic [15:0]           lag,
	output logic [MEM_ADDR_W-1:0]      read_addr,
	output logic                       buffer_done,
	output logic [SAMPLE_W-1:0]        got [64],
	output int                         n_got
);
	initial begin
		logic b;
		read_addr = '0;
		buffer_done = 1'b0;
		n_got = 0;
		forever begin
			@(posedge clk);
			if (full_event === 1'b1 && !rst) begin
				b = full_index;
				repeat (lag) @(posedge clk);
				for (int i = 0; i < int'(buf_len); i++) begin
					read_addr <= {b, (MEM_ADDR_W-1)'(i)};
					repeat (2) @(posedge clk);
					got[n_got] = read_data;
					n_got++;
				end
				buffer_done <= 1'b1;
				@(posedge clk);
				buffer_done <= 1'b0;
			end
		end
	end
endmodule : aspb_host_model

//--- testbench/aspb_tb_top.sv
// Purpose: Self-checking bench for the acquisition ping-pong buffer.
// Assumes: Host model drains each full buffer after a set lag.
// Notes:   Rows cover sample format; runs cover order, triggers, overrun.
`timescale 1ns/10ps
module aspb_tb_top
	import aspb_pkg::*;
;
	typedef struct packed {
		logic [15:0] raw;
		logic [15:0] off;
		logic [15:0] exp;
	} aspb_row_type;
	localparam logic [47:0] ROWS [8] = '{
		48'h0000_0000_0000,
		48'h7d00_0000_7d00,
		48'h8300_0000_8300,
		48'h7cf0_0010_7d00,
		48'h8310_fff0_8300,
		48'h7d00_0100_7e00,
		48'h8300_ff00_8200,
		48'h8001_0001_8002
	};
	localparam logic [7:0] CHL [3] = '{8'h00, 8'h02, 8'h03};
	logic CORE_CLK = 1'b0;
	logic RST = 1'b1;
	logic [SAMPLE_W*NUM_CH-1:0] CONVERTER_SAMPLE_BITS = '0;
	logic SAMPLE_STROBE = 1'b0, START = 1'b0, STOP = 1'b0;
	logic SOFT_TRIGGER = 1'b0, EXT_TRIGGER = 1'b0;
	logic [7:0] CHANNEL_ENABLE = 8'h01;
	logic [15:0] OFFSET_CONST = 16'h0000;
	logic [LEN_W-1:0] BUFFER_LEN = 12'h008;
	logic BUFFER_DONE, BUFFER_FULL_EVENT, FULL_BUFFER_INDEX, RUNNING, ARMED, OVERRUN;
	logic [MEM_ADDR_W-1:0] READ_ADDR;
	logic [15:0] READ_DATA;
	logic [15:0] lag = 16'h0002;
	logic [15:0] got [64];
	int n_got;
	int n_errors = 0;
	int comparisons = 0;

	always #5 CORE_CLK = ~CORE_CLK;

	aspb_top uut (.CORE_CLK(CORE_CLK), .RST(RST), .CONVERTER_SAMPLE_BITS(CONVERTER_SAMPLE_BITS),
		.SAMPLE_STROBE(SAMPLE_STROBE), .CHANNEL_ENABLE(CHANNEL_ENABLE),
		.OFFSET_CONST(OFFSET_CONST), .BUFFER_LEN(BUFFER_LEN), .START(START), .STOP(STOP),
		.SOFT_TRIGGER(SOFT_TRIGGER), .EXT_TRIGGER(EXT_TRIGGER), .BUFFER_DONE(BUFFER_DONE),
		.READ_ADDR(READ_ADDR), .READ_DATA(READ_DATA), .BUFFER_FULL_EVENT(BUFFER_FULL_EVENT),
		.FULL_BUFFER_INDEX(FULL_BUFFER_INDEX), .RUNNING(RUNNING), .ARMED(ARMED),
		.OVERRUN(OVERRUN));

	aspb_host_model host (.clk(CORE_CLK), .rst(RST), .full_event(BUFFER_FULL_EVENT),
		.full_index(FULL_BUFFER_INDEX), .read_data(READ_DATA), .buf_len(BUFFER_LEN),
		.lag(lag), .read_addr(READ_ADDR), .buffer_done(BUFFER_DONE), .got(got),
		.n_got(n_got));

	task automatic check(input logic [15:0] g, input logic [15:0] e, input string m);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : check

	task automatic stop_test();
		if (n_errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test

	function automatic logic [127:0] pins(input logic [7:0] s);
		for (int c = 0; c < 8; c++) begin
			pins[16*c +: 16] = {8'(c), s};
		end
	endfunction : pins

	// Strobe spacing of 14 cycles covers eight channels plus the pipeline.
	task automatic step(input logic [127:0] p);
		CONVERTER_SAMPLE_BITS <= p;
		@(posedge CORE_CLK);
		SAMPLE_STROBE <= 1'b1;
		repeat (3) @(posedge CORE_CLK);
		SAMPLE_STROBE <= 1'b0;
		repeat (10) @(posedge CORE_CLK);
	endtask : step

	task automatic begin_run(input logic [7:0] mask, input logic [11:0] len);
		STOP <= 1'b1;
		CHANNEL_ENABLE <= mask;
		BUFFER_LEN <= len;
		@(posedge CORE_CLK);
		STOP <= 1'b0;
		START <= 1'b1;
		@(posedge CORE_CLK);
		START <= 1'b0;
		@(posedge CORE_CLK);
		check(ARMED, 1'b1, "armed");
		check(OVERRUN, 1'b0, "overrun clear");
	endtask : begin_run

	task automatic trig();
		SOFT_TRIGGER <= 1'b1;
		@(posedge CORE_CLK);
		SOFT_TRIGGER <= 1'b0;
		@(posedge CORE_CLK);
		check(RUNNING, 1'b1, "running");
	endtask : trig

	task automatic wait_got(input int n);
		for (int k = 0; k < 400 && n_got < n; k++) begin
			@(posedge CORE_CLK);
		end
	endtask : wait_got

	initial begin
		aspb_row_type r;
		repeat (6) @(posedge CORE_CLK);
		RST <= 1'b0;
		@(posedge CORE_CLK);
		check(RUNNING | ARMED | OVERRUN | BUFFER_FULL_EVENT, 1'b0, "reset");
		begin_run(8'h01, 12'h008);
		trig();
		for (int i = 0; i < 8; i++) begin
			r = ROWS[i];
			OFFSET_CONST <= r.off;
			step({{7{16'h1234}}, r.raw});
		end
		wait_got(8);
		for (int i = 0; i < 8; i++) begin
			r = ROWS[i];
			check(got[i], r.exp, "stored word");
		end
		// A strobe while armed must not be stored.
		OFFSET_CONST <= 16'h0000;
		begin_run(8'h0d, 12'h006);
		step(pins(8'h09));
		EXT_TRIGGER <= 1'b1;
		repeat (8) @(posedge CORE_CLK);
		EXT_TRIGGER <= 1'b0;
		check(RUNNING, 1'b1, "ext trigger");
		for (int s = 0; s < 4; s++) begin
			step(pins(8'(s)));
		end
		wait_got(20);
		for (int s = 0; s < 4; s++) begin
			for (int j = 0; j < 3; j++) begin
				check(got[8+3*s+j], {CHL[j], 8'(s)}, "interleave");
			end
		end
		check(RUNNING, 1'b1, "still running");
		check(OVERRUN, 1'b0, "no overrun");
		check(FULL_BUFFER_INDEX, 1'b1, "second buffer");
		lag <= 16'd1000;
		begin_run(8'h00, 12'h006);
		trig();
		for (int s = 0; s < 11; s++) begin
			step(pins(8'(s)));
		end
		check(RUNNING, 1'b1, "second buffer filling");
		step(pins(8'h0b));
		repeat (4) @(posedge CORE_CLK);
		check(OVERRUN, 1'b1, "overrun flag");
		check(RUNNING, 1'b0, "overrun stop");
		begin_run(8'h01, 12'h006);
		stop_test();
	end

	initial begin
		repeat (5000) @(posedge CORE_CLK);
		n_errors++;
		stop_test();
	end
endmodule : aspb_tb_top
